// >>> verilog/stc_pkg.sv
// Shared constants and types for the sync, thermal and calibration control.
package stc_pkg;
   // Register indices on the device side of the link.
   localparam logic [5:0] STC_REG_CTRL = 6'h00;
   localparam logic [5:0] STC_REG_FALL_FLAG = 6'h01;
   localparam logic [5:0] STC_REG_RISE_FLAG = 6'h02;
   localparam logic [5:0] STC_REG_SYNC_SHIFT = 6'h03;
   localparam logic [5:0] STC_REG_THERM_GO = 6'h04;
   localparam logic [5:0] STC_REG_THERM_WIN = 6'h05;
   localparam logic [5:0] STC_REG_THERM_MEAN = 6'h06;
   localparam logic [5:0] STC_REG_THERM_NOW = 6'h07;
   localparam logic [5:0] STC_REG_OFFSET_ENA = 6'h08;
   localparam logic [5:0] STC_REG_GAIN_ENA = 6'h09;
   localparam logic [5:0] STC_REG_SOFT_SYNC = 6'h0A;
   localparam logic [5:0] STC_REG_THERM_SRC = 6'h0B;
   // Calibration enable fields and reset value (factory on, adaptive off).
   localparam int STC_CAL_ADAPT_REFRESH = 0;
   localparam int STC_CAL_CORE_REFRESH = 1;
   localparam int STC_CAL_COMMON_REFRESH = 2;
   localparam int STC_CAL_ADAPT_SEL = 3;
   localparam int STC_CAL_CORE_SEL = 4;
   localparam int STC_CAL_COMMON_SEL = 5;
   localparam logic [15:0] STC_CAL_RESET = 16'h0036;
   localparam logic [15:0] STC_WIN_RESET = 16'h0010;
   localparam logic [15:0] STC_SHIFT_RESET = 16'h0000;
   localparam int STC_INVALID_BIT = 15;
   // Thermal refresh time and the host's least wait.
   localparam int STC_CLK_MHZ = 100;
   localparam int STC_THERM_PERIOD_CYC = 128;
   localparam int STC_THERM_WAIT_NS = 1840;
   localparam int STC_THERM_WAIT_CYC = (STC_THERM_WAIT_NS * STC_CLK_MHZ
                                        + 999) / 1000;
   // Host registers.
   localparam logic [3:0] STC_H_ADDR = 4'h0;
   localparam logic [3:0] STC_H_WDATA = 4'h1;
   localparam logic [3:0] STC_H_GO = 4'h2;
   localparam logic [3:0] STC_H_STATUS = 4'h3;
   localparam logic [3:0] STC_H_RDATA = 4'h4;
   localparam logic [3:0] STC_H_IRQ_STAT = 4'h5;
   localparam logic [3:0] STC_H_IRQ_MASK = 4'h6;
   localparam logic [3:0] STC_H_SYNC = 4'h7;
   localparam int STC_H_GO_WRITE = 0;
   localparam int STC_H_GO_READ = 1;
   localparam int STC_H_GO_THERM = 2;
   localparam int STC_EV_DONE = 0;
   localparam int STC_EV_THERM = 1;
   localparam int STC_EV_INVALID = 2;
   localparam int STC_SCLK_HALF = 4;
   localparam int STC_FRAME_BITS = 24;
   typedef enum logic [1:0] {
      STC_S_IDLE = 2'b00,
      STC_S_SHIFT = 2'b01,
      STC_S_END = 2'b10
   } stc_spi_st_t;
endpackage : stc_pkg

// >>> verilog/stc_link_if.sv
// Link between host and device: serial port plus sync pins.
`timescale 1ns/1ns
interface stc_link_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic sync_input_pair;
   logic sync_chain_output_pair;
   modport dev (
      input sclk, cs_n, mosi, sync_input_pair,
      output miso, sync_chain_output_pair
   );
   modport host (
      output sclk, cs_n, mosi, sync_input_pair,
      input miso, sync_chain_output_pair
   );
endinterface : stc_link_if

// >>> verilog/stc_sync2.sv
// Two-flop synchroniser for a vector of levels.
`timescale 1ns/1ns
module stc_sync2 #(
   parameter int W = 1
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule : stc_sync2

// >>> verilog/stc_device.sv
// Device end: sync capture, thermal sampler, calibration enables, SPI slave.
// Operation
// - Sync pin sampled at half sample rate.
// - Only a rising edge is taken; rearms once sync is low.
// - Latched sync forwarded to chain output.
// - Separate fall and rise forbidden-zone flags; the fall flag never sets, as only rising edges are taken.
// - Reading a flag register clears it.
// - Sync delay of 1 to 16 clocks.
// - Thermal go bit starts measurement.
// - Instant and mean over N samples.
// - Host trusts mean after N samples.
// - Results are signed 8.2 fixed point.
// - Results carry invalid flag; host raises an event.
// - Periodic refresh; host waits 1.84 us.
// - Adaptive offset and gain error estimation.
// - Offset and gain enables are independent.
// - Factory on, adaptive off after reset.
// - Host avoids Fs/64 multiples, needs input.
// - Factory coefficients seed adaptive estimates.
// - Pin sync default, soft sync selectable.
`timescale 1ns/1ns
module stc_dev #(
   parameter int WIN_MAX = 256
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   stc_link_if.dev link,
   input wire logic [9:0] temp_sample_i,
   input wire logic temp_range_ok_i,
   input wire logic signed [9:0] core_mean_i,
   input wire logic signed [9:0] global_mean_i,
   input wire logic [9:0] core_rms_i,
   input wire logic [9:0] global_rms_i,
   input wire logic [9:0] factory_offset_i,
   input wire logic [9:0] factory_gain_i,
   input wire logic sync_forbidden_i,
   output logic sync_internal_o,
   output logic signed [9:0] offset_err_o,
   output logic [9:0] gain_err_o,
   output logic [15:0] offset_correction_enables_o,
   output logic [15:0] gain_correction_enables_o,
   output logic thermal_source_on_o
);
   import stc_pkg::*;
   logic [3:0] pins_s;
   stc_sync2 #(.W(4)) u_sync (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .d_i({link.sclk, link.cs_n, link.mosi, link.sync_input_pair}),
      .q_o(pins_s)
   );
   wire sclk_s = pins_s[3];
   wire cs_n_s = pins_s[2];
   wire mosi_s = pins_s[1];
   wire sync_s = pins_s[0];
   // SPI slave: 1 r/w bit, 1 unused bit, 6 addr, 16 data, MSB first, mode 0.
   logic sclk_d_reg, half_reg, sync_lat_reg, sync_prev_reg, armed_reg;
   logic [4:0] bit_reg;
   logic [23:0] sh_reg;
   logic [15:0] tx_reg;
   logic miso_reg;
   wire sclk_rise = sclk_s & ~sclk_d_reg;
   wire sclk_fall = ~sclk_s & sclk_d_reg;
   wire [23:0] sh_next = {sh_reg[22:0], mosi_s};
   wire hdr_done = ~cs_n_s & sclk_rise & (bit_reg == 5'd7);
   wire frm_done = ~cs_n_s & sclk_rise & (bit_reg == 5'd23);
   wire is_rd = sh_next[7];
   wire [5:0] hdr_addr = sh_next[5:0];
   wire wr_en = frm_done & ~sh_next[23];
   wire [5:0] wr_addr = sh_next[21:16];
   wire [15:0] wr_data = sh_next[15:0];
   // Registers.
   logic [15:0] offset_reg, gain_reg, win_reg, mean_reg, now_reg;
   logic [3:0] shift_reg;
   logic go_reg, soft_sel_reg, soft_pulse_reg, src_reg;
   logic fall_flag_reg, rise_flag_reg;
   logic [15:0] rd_mux;
   always_comb begin
      case (hdr_addr)
         STC_REG_FALL_FLAG: rd_mux = {15'h0000, fall_flag_reg};
         STC_REG_RISE_FLAG: rd_mux = {15'h0000, rise_flag_reg};
         STC_REG_SYNC_SHIFT: rd_mux = {12'h000, shift_reg};
         STC_REG_THERM_GO: rd_mux = {15'h0000, go_reg};
         STC_REG_THERM_WIN: rd_mux = win_reg;
         STC_REG_THERM_MEAN: rd_mux = mean_reg;
         STC_REG_THERM_NOW: rd_mux = now_reg;
         STC_REG_OFFSET_ENA: rd_mux = offset_reg;
         STC_REG_GAIN_ENA: rd_mux = gain_reg;
         STC_REG_SOFT_SYNC: rd_mux = {15'h0000, soft_sel_reg};
         STC_REG_THERM_SRC: rd_mux = {15'h0000, src_reg};
         default: rd_mux = 16'h0000;
      endcase
   end
   wire rd_fall = hdr_done & is_rd & (hdr_addr == STC_REG_FALL_FLAG);
   wire rd_rise = hdr_done & is_rd & (hdr_addr == STC_REG_RISE_FLAG);
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i | cs_n_s) begin
         bit_reg <= 5'd0;
         sh_reg <= 24'h0000_00;
         tx_reg <= 16'h0000;
         miso_reg <= 1'b0;
      end else begin
         if (sclk_rise) begin
            sh_reg <= sh_next;
            bit_reg <= (bit_reg == 5'd23) ? 5'd0 : bit_reg + 5'd1;
         end
         if (hdr_done && is_rd) begin
            tx_reg <= rd_mux;
         end else if (sclk_fall && bit_reg >= 5'd8) begin
            miso_reg <= tx_reg[15];
            tx_reg <= {tx_reg[14:0], 1'b0};
         end
      end
   end
   assign link.miso = miso_reg;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sclk_d_reg <= 1'b0;
         offset_reg <= STC_CAL_RESET;
         gain_reg <= STC_CAL_RESET;
         win_reg <= STC_WIN_RESET;
         shift_reg <= STC_SHIFT_RESET[3:0];
         go_reg <= 1'b0;
         soft_sel_reg <= 1'b0;
         soft_pulse_reg <= 1'b0;
         src_reg <= 1'b1;
      end else begin
         sclk_d_reg <= sclk_s;
         // Hold the soft pulse until a half-rate sample has seen it.
         soft_pulse_reg <= (soft_pulse_reg & ~half_reg)
                           | (wr_en & (wr_addr == STC_REG_SOFT_SYNC)
                              & wr_data[1]);
         if (wr_en) begin
            case (wr_addr)
               STC_REG_SYNC_SHIFT: shift_reg <= wr_data[3:0];
               STC_REG_THERM_GO: go_reg <= wr_data[0];
               STC_REG_THERM_WIN: win_reg <= wr_data;
               STC_REG_OFFSET_ENA: offset_reg <= wr_data;
               STC_REG_GAIN_ENA: gain_reg <= wr_data;
               STC_REG_SOFT_SYNC: soft_sel_reg <= wr_data[0];
               STC_REG_THERM_SRC: src_reg <= wr_data[0];
               default: ;
            endcase
         end
      end
   end
   // Sync path, latched on alternate cycles to model the half-rate clock.
   wire sync_src = soft_sel_reg ? soft_pulse_reg : sync_s;
   wire first_edge = half_reg & armed_reg & (sync_src != sync_prev_reg);
   logic [15:0] dly_reg;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         half_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
         armed_reg <= 1'b1;
         sync_lat_reg <= 1'b0;
         dly_reg <= 16'h0000;
         fall_flag_reg <= 1'b0;
         rise_flag_reg <= 1'b0;
      end else begin
         half_reg <= ~half_reg;
         // One cycle wide: first_edge is only true on half-rate cycles.
         sync_lat_reg <= first_edge;
         if (half_reg) begin
            sync_prev_reg <= sync_src;
            if (first_edge) begin
               armed_reg <= 1'b0;
            end else if (sync_src == 1'b0 && !armed_reg) begin
               armed_reg <= 1'b1;
            end
         end
         dly_reg <= {dly_reg[14:0], sync_lat_reg};
         // Set beats the clear-on-read in the same cycle.
         if (first_edge && sync_forbidden_i && !sync_src) begin
            fall_flag_reg <= 1'b1;
         end else if (rd_fall) begin
            fall_flag_reg <= 1'b0;
         end
         if (first_edge && sync_forbidden_i && sync_src) begin
            rise_flag_reg <= 1'b1;
         end else if (rd_rise) begin
            rise_flag_reg <= 1'b0;
         end
      end
   end
   // A setting of k delays by k+1 clocks.
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sync_internal_o <= 1'b0;
         link.sync_chain_output_pair <= 1'b0;
      end else begin
         sync_internal_o <= dly_reg[shift_reg];
         link.sync_chain_output_pair <= sync_lat_reg;
      end
   end
   // Thermal sampler.
   logic [7:0] tick_reg;
   logic [15:0] cnt_reg;
   logic signed [25:0] acc_reg;
   logic signed [9:0] mem_reg [WIN_MAX];
   logic [$clog2(WIN_MAX)-1:0] wp_reg;
   wire tick = go_reg & (tick_reg == 8'(STC_THERM_PERIOD_CYC - 1));
   wire [15:0] n_eff = (win_reg == 16'h0000) ? 16'h0001 : win_reg;
   wire full = cnt_reg >= n_eff;
   wire signed [9:0] old_s = mem_reg[wp_reg];
   wire signed [25:0] acc_next = acc_reg + 26'(signed'(temp_sample_i))
                                 - (full ? 26'(old_s) : 26'sd0);
   wire signed [25:0] avg = acc_next / $signed({10'h000, n_eff});
   wire [$clog2(WIN_MAX)-1:0] wp_next =
      (32'(wp_reg) + 1 >= 32'(n_eff)) ? '0 : wp_reg + 1'b1;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !go_reg) begin
         tick_reg <= 8'h00;
         cnt_reg <= 16'h0000;
         acc_reg <= '0;
         wp_reg <= '0;
      end else begin
         tick_reg <= tick ? 8'h00 : tick_reg + 8'h01;
         if (tick) begin
            mem_reg[wp_reg] <= signed'(temp_sample_i);
            acc_reg <= acc_next;
            wp_reg <= wp_next;
            if (!full) begin
               cnt_reg <= cnt_reg + 16'h0001;
            end
         end
      end
   end
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         now_reg <= 16'h0000;
         mean_reg <= 16'h0000;
      end else if (tick) begin
         now_reg <= {~temp_range_ok_i, 5'h00, temp_sample_i};
         mean_reg <= {~temp_range_ok_i, 5'h00, avg[9:0]};
      end
   end
   // Calibration error: difference for offset, ratio for gain.
   wire cal_adapt_o = offset_reg[STC_CAL_ADAPT_SEL];
   wire cal_adapt_g = gain_reg[STC_CAL_ADAPT_SEL];
   wire upd_o = offset_reg[STC_CAL_ADAPT_REFRESH];
   wire upd_g = gain_reg[STC_CAL_ADAPT_REFRESH];
   wire signed [9:0] o_est = core_mean_i - global_mean_i;
   wire [19:0] g_q = ({core_rms_i, 10'h000}) /
                     ((global_rms_i == 10'h000) ? 20'h0_0001 :
                      {10'h000, global_rms_i});
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         offset_err_o <= '0;
         gain_err_o <= '0;
         offset_correction_enables_o <= STC_CAL_RESET;
         gain_correction_enables_o <= STC_CAL_RESET;
         thermal_source_on_o <= 1'b1;
      end else begin
         // Factory values seed the estimate until adaptive updates run.
         if (!cal_adapt_o || !upd_o) begin
            offset_err_o <= factory_offset_i;
         end else begin
            offset_err_o <= o_est;
         end
         if (!cal_adapt_g || !upd_g) begin
            gain_err_o <= factory_gain_i;
         end else begin
            gain_err_o <= g_q[9:0];
         end
         offset_correction_enables_o <= offset_reg;
         gain_correction_enables_o <= gain_reg;
         thermal_source_on_o <= src_reg;
      end
   end
endmodule : stc_dev

// >>> verilog/stc_host.sv
// Host end: SPI master driven by software registers, sync pulse source.
`timescale 1ns/1ns
module stc_host (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   stc_link_if.host link,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   output logic irq_o
);
   import stc_pkg::*;
   logic miso_s, sclk_reg, cs_n_reg, mosi_reg, sync_reg;
   stc_sync2 #(.W(1)) u_sync (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .d_i(link.miso),
      .q_o(miso_s)
   );
   stc_spi_st_t st_reg;
   logic [5:0] addr_reg;
   logic [15:0] wd_reg, rd_reg;
   logic [2:0] ev_stat_reg, ev_mask_reg;
   logic [2:0] div_reg;
   logic [4:0] bit_reg;
   logic [23:0] sh_reg;
   logic rd_op_reg, therm_reg;
   logic [15:0] wait_reg;
   wire busy = (st_reg != STC_S_IDLE);
   wire go_w = wr_i & (addr_i == STC_H_GO) & ~busy;
   wire tick = (div_reg == 3'(STC_SCLK_HALF - 1));
   wire done_ev = (st_reg == STC_S_END) & tick;
   // Flag results marked invalid; report thermal only after the least wait.
   wire inval = done_ev & rd_op_reg & rd_reg[STC_INVALID_BIT];
   wire therm_ev = done_ev & rd_op_reg & therm_reg
                   & (wait_reg == 16'h0000);
   logic [2:0] ev;
   assign ev = {inval, therm_ev, done_ev};
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         st_reg <= STC_S_IDLE;
         addr_reg <= 6'h00;
         wd_reg <= 16'h0000;
         rd_reg <= 16'h0000;
         ev_stat_reg <= 3'h0;
         ev_mask_reg <= 3'h0;
         div_reg <= 3'h0;
         bit_reg <= 5'h00;
         sh_reg <= 24'h0000_00;
         sclk_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         mosi_reg <= 1'b0;
         sync_reg <= 1'b0;
         rd_op_reg <= 1'b0;
         therm_reg <= 1'b0;
         wait_reg <= 16'h0000;
         rdata_o <= 16'h0000;
         irq_o <= 1'b0;
      end else begin
         // New events win over a write-one clear.
         ev_stat_reg <= (ev_stat_reg & ~((wr_i && addr_i == STC_H_IRQ_STAT)
                         ? wdata_i[2:0] : 3'h0)) | ev;
         irq_o <= |(ev_stat_reg & ev_mask_reg);
         if (wait_reg != 16'h0000) begin
            wait_reg <= wait_reg - 16'h0001;
         end
         if (wr_i) begin
            case (addr_i)
               STC_H_ADDR: addr_reg <= wdata_i[5:0];
               STC_H_WDATA: wd_reg <= wdata_i;
               STC_H_IRQ_MASK: ev_mask_reg <= wdata_i[2:0];
               STC_H_SYNC: sync_reg <= wdata_i[0];
               default: ;
            endcase
         end
         if (go_w && wdata_i[STC_H_GO_THERM]) begin
            wait_reg <= 16'(STC_THERM_WAIT_CYC);
         end
         case (st_reg)
            STC_S_IDLE: begin
               if (go_w) begin
                  rd_op_reg <= wdata_i[STC_H_GO_READ];
                  therm_reg <= wdata_i[STC_H_GO_THERM];
                  sh_reg <= {wdata_i[STC_H_GO_READ], 1'b0,
                             (wr_i && addr_i == STC_H_ADDR) ? wdata_i[5:0]
                             : addr_reg, wd_reg};
                  cs_n_reg <= 1'b0;
                  div_reg <= 3'h0;
                  bit_reg <= 5'h00;
                  st_reg <= STC_S_SHIFT;
               end
            end
            STC_S_SHIFT: begin
               div_reg <= tick ? 3'h0 : div_reg + 3'h1;
               if (tick) begin
                  if (!sclk_reg) begin
                     mosi_reg <= sh_reg[23];
                     sclk_reg <= 1'b1;
                  end else begin
                     sclk_reg <= 1'b0;
                     sh_reg <= {sh_reg[22:0], 1'b0};
                     // Data bits follow the eight header bits.
                     if (bit_reg >= 5'd8) begin
                        rd_reg <= {rd_reg[14:0], miso_s};
                     end
                     if (bit_reg == 5'(STC_FRAME_BITS - 1)) begin
                        st_reg <= STC_S_END;
                     end
                     bit_reg <= bit_reg + 5'h01;
                  end
               end
            end
            STC_S_END: begin
               div_reg <= tick ? 3'h0 : div_reg + 3'h1;
               if (tick) begin
                  cs_n_reg <= 1'b1;
                  st_reg <= STC_S_IDLE;
               end
            end
            default: st_reg <= STC_S_IDLE;
         endcase
         if (rd_i) begin
            case (addr_i)
               STC_H_STATUS: rdata_o <= {15'h0000, busy};
               STC_H_RDATA: rdata_o <= rd_reg;
               STC_H_IRQ_STAT: rdata_o <= {13'h0000, ev_stat_reg};
               STC_H_IRQ_MASK: rdata_o <= {13'h0000, ev_mask_reg};
               STC_H_ADDR: rdata_o <= {10'h000, addr_reg};
               STC_H_WDATA: rdata_o <= wd_reg;
               default: rdata_o <= 16'h0000;
            endcase
         end
      end
   end
   assign link.sclk = sclk_reg;
   assign link.cs_n = cs_n_reg;
   assign link.mosi = mosi_reg;
   assign link.sync_input_pair = sync_reg;
endmodule : stc_host

// >>> verif/stc_link_props.sv
// Checker for the sync pins and serial port between host and device ends.
`timescale 1ns/1ns
module stc_link_props (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic sync_input_pair,
   input wire logic sync_chain_output_pair
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence sclk_high_s;
      sclk [*4] ##1 !sclk;
   endsequence
   sequence sclk_low_s;
      !sclk [*4];
   endsequence
   chain_pulse_a: assert property (
      $rose(sync_chain_output_pair) |=> !sync_chain_output_pair)
      else $error("chain output high for more than one cycle");
   chain_follow_a: assert property (
      $rose(sync_input_pair) |-> ##[1:10] sync_chain_output_pair)
      else $error("sync edge not forwarded to chain output");
   chain_cause_a: assert property (
      $rose(sync_chain_output_pair)
      |-> sync_input_pair && !$past(sync_input_pair, 10))
      else $error("chain output without a recent sync edge");
   first_edge_a: assert property (
      sync_input_pair && $past(sync_input_pair, 12)
      |-> !sync_chain_output_pair)
      else $error("second chain pulse while sync held");
   cs_idle_a: assert property (cs_n |-> !sclk)
      else $error("serial clock high while deselected");
   sclk_high_a: assert property ($rose(sclk) |-> sclk_high_s)
      else $error("serial clock high phase not four cycles");
   sclk_low_a: assert property ($fell(sclk) |-> sclk_low_s)
      else $error("serial clock low phase under four cycles");
   mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("serial data moved while clock high");
endmodule : stc_link_props

// >>> verif/sync_temp_cal_control_test.sv
// Self-checking bench joining host and device ends over the link.
`timescale 1ns/1ns
module sync_temp_cal_control_test;
   import stc_pkg::*;
   logic mclk_i, sys_rst_i, wr, rd, forb, rng_ok, sync_int, irq, tsrc;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, q, oena, gena;
   logic [9:0] temp, crms, grms, gerr, fofs, fgain;
   logic signed [9:0] cmean, gmean, oerr;
   int errors, checks_done, chain_cnt, dcnt, dly, d0;
   stc_link_if link();
   stc_host u_stc_host (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .link(link), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .irq_o(irq));
   stc_dev u_stc_dev (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link),
      .temp_sample_i(temp), .temp_range_ok_i(rng_ok),
      .core_mean_i(cmean), .global_mean_i(gmean), .core_rms_i(crms),
      .global_rms_i(grms), .factory_offset_i(fofs),
      .factory_gain_i(fgain), .sync_forbidden_i(forb),
      .sync_internal_o(sync_int), .offset_err_o(oerr), .gain_err_o(gerr),
      .offset_correction_enables_o(oena), .gain_correction_enables_o(gena),
      .thermal_source_on_o(tsrc));
   stc_link_props u_stc_link_props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
      .miso(link.miso), .sync_input_pair(link.sync_input_pair),
      .sync_chain_output_pair(link.sync_chain_output_pair));
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // Delay is timed from the chain pulse, which removes the half-rate jitter.
   always @(posedge mclk_i) begin
      if (link.sync_chain_output_pair === 1'b1) begin
         chain_cnt++;
         dcnt = 0;
      end else dcnt++;
      if (sync_int === 1'b1) dly = dcnt;
   end
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      @(negedge mclk_i);
      d = rdata;
   endtask : rd_reg
   task automatic dev_op(input logic [5:0] a, input logic [15:0] d,
                         input int go, output logic [15:0] r);
      int n;
      logic [15:0] s;
      n = 0;
      wr_reg(STC_H_ADDR, {10'h000, a});
      wr_reg(STC_H_WDATA, d);
      wr_reg(STC_H_GO, 16'h0001 << go);
      do begin
         rd_reg(STC_H_STATUS, s);
         n++;
      end while (s[0] !== 1'b0 && n < 1000);
      if (n >= 1000) begin
         errors++;
         finish_test;
      end
      rd_reg(STC_H_RDATA, r);
   endtask : dev_op
   task automatic t_cal;
      chk({6'h00, oerr}, 16'h0015);
      chk({6'h00, gerr}, 16'h002A);
      chk({15'h0000, tsrc}, 16'h0001);
      dev_op(STC_REG_OFFSET_ENA, 16'h0000, 1, q);
      chk(q, STC_CAL_RESET);
      dev_op(STC_REG_GAIN_ENA, 16'h0000, 1, q);
      chk(q, STC_CAL_RESET);
      dev_op(STC_REG_THERM_WIN, 16'h0000, 1, q);
      chk(q, STC_WIN_RESET);
      dev_op(STC_REG_OFFSET_ENA, 16'h003F, 0, q);
      dev_op(STC_REG_OFFSET_ENA, 16'h0000, 1, q);
      chk(q, 16'h003F);
      chk(oena, 16'h003F);
      chk(gena, STC_CAL_RESET);
      repeat (50) @(posedge mclk_i);
      chk({6'h00, oerr}, 16'h0003);
      dev_op(STC_REG_GAIN_ENA, 16'h003F, 0, q);
      chk(gena, 16'h003F);
      chk({6'h00, gerr}, 16'h0200);
   endtask : t_cal
   task automatic t_irq;
      wr_reg(STC_H_IRQ_MASK, 16'h0000);
      wr_reg(STC_H_IRQ_STAT, 16'hFFFF);
      dev_op(STC_REG_CTRL, 16'h0000, 1, q);
      rd_reg(STC_H_IRQ_STAT, q);
      chk(q & 16'h0001, 16'h0001);
      chk({15'h0000, irq}, 16'h0000);
      wr_reg(STC_H_IRQ_MASK, 16'h0001);
      repeat (2) @(posedge mclk_i);
      chk({15'h0000, irq}, 16'h0001);
      wr_reg(STC_H_IRQ_STAT, 16'h0001);
      repeat (2) @(posedge mclk_i);
      chk({15'h0000, irq}, 16'h0000);
      rd_reg(4'hF, q);
      chk(q, 16'h0000);
   endtask : t_irq
   // Long pulses keep each edge well clear of the rearm window.
   task automatic pulse;
      wr_reg(STC_H_SYNC, 16'h0001);
      repeat (40) @(posedge mclk_i);
      wr_reg(STC_H_SYNC, 16'h0000);
      repeat (40) @(posedge mclk_i);
   endtask : pulse
   task automatic t_sync;
      int c;
      c = chain_cnt;
      forb <= 1'b1;
      pulse;
      forb <= 1'b0;
      chk(16'(chain_cnt - c), 16'h0001);
      dev_op(STC_REG_RISE_FLAG, 16'h0000, 1, q);
      chk(q, 16'h0001);
      dev_op(STC_REG_RISE_FLAG, 16'h0000, 1, q);
      chk(q, 16'h0000);
      dev_op(STC_REG_FALL_FLAG, 16'h0000, 1, q);
      dev_op(STC_REG_FALL_FLAG, 16'h0000, 1, q);
      chk(q, 16'h0000);
      d0 = dly;
      chk(16'(d0), 16'h0001);
      dev_op(STC_REG_SYNC_SHIFT, 16'h000F, 0, q);
      pulse;
      chk(16'(dly - d0), 16'h000F);
   endtask : t_sync
   task automatic t_therm;
      dev_op(STC_REG_THERM_WIN, 16'h0004, 0, q);
      dev_op(STC_REG_THERM_GO, 16'h0001, 0, q);
      repeat (700) @(posedge mclk_i);
      dev_op(STC_REG_THERM_NOW, 16'h0000, 1, q);
      chk({q[15], 5'h00, q[9:0]}, 16'h03F6);
      dev_op(STC_REG_THERM_MEAN, 16'h0000, 1, q);
      chk({q[15], 5'h00, q[9:0]}, 16'h03F6);
      rng_ok <= 1'b0;
      repeat (300) @(posedge mclk_i);
      dev_op(STC_REG_THERM_NOW, 16'h0000, 1, q);
      chk({q[15], 5'h00, q[9:0]}, 16'h83F6);
      rd_reg(STC_H_IRQ_STAT, q);
      chk(q & 16'h0004, 16'h0004);
      dev_op(STC_REG_THERM_GO, 16'h0000, 0, q);
      rng_ok <= 1'b1;
      temp <= 10'h010;
      repeat (300) @(posedge mclk_i);
      dev_op(STC_REG_THERM_NOW, 16'h0000, 1, q);
      chk({q[15], 5'h00, q[9:0]}, 16'h83F6);
      dev_op(STC_REG_THERM_GO, 16'h0001, 0, q);
      repeat (700) @(posedge mclk_i);
      dev_op(STC_REG_THERM_MEAN, 16'h0000, 1, q);
      chk({q[15], 5'h00, q[9:0]}, 16'h0010);
   endtask : t_therm
   initial begin
      {addr, wdata, wr, rd, forb} = '0;
      rng_ok = 1'b1;
      temp = 10'h3F6;
      cmean = 10'sd5;
      gmean = 10'sd2;
      crms = 10'h008;
      grms = 10'h010;
      fofs = 10'h015;
      fgain = 10'h02A;
      sys_rst_i = 1'b1;
      repeat (6) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      t_cal;
      t_irq;
      t_sync;
      t_therm;
      finish_test;
   end
endmodule : sync_temp_cal_control_test
